// *** core/ars_pkg.sv ***
// shared constants and types for the receiver status register bank
// assumes a 100 MHz system clock and a classic wishbone master
package ars_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0] REG_CLK_RATE_IDX = 8'h13;
  localparam logic [7:0] REG_EVENT_IDX = 8'h14;
  localparam logic [7:0] REG_MASK_IDX = 8'h16;
  localparam logic [7:0] REG_PEND_IDX = 8'h1A;
  localparam int unsigned WB_ADR_W = 8;
  localparam int unsigned WB_DAT_W = 32;
  localparam int unsigned WB_SEL_W = 4;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned REG_W = 8;

  // event register bit positions
  localparam int unsigned BIT_CS_CRC = 7;
  localparam int unsigned BIT_PARITY = 6;
  localparam int unsigned BIT_VALIDITY = 5;
  localparam int unsigned BIT_BIPHASE = 4;
  localparam int unsigned BIT_SUB_CHG = 3;
  localparam int unsigned BIT_UNLOCK = 2;
  localparam int unsigned BIT_SUB_CRC = 1;
  localparam int unsigned BIT_XFER = 0;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] PEND_RESET = 8'h00;

  typedef enum logic [1:0] {
    RATE_UNDET = 2'h0,
    RATE_128FS = 2'h1,
    RATE_256FS = 2'h2,
    RATE_512FS = 2'h3
  } ars_rate_t;

  // recovered clock divide shifts: log2 of the multiple of fs
  localparam int unsigned SHIFT_128FS = 7;
  localparam int unsigned SHIFT_256FS = 8;
  localparam int unsigned SHIFT_512FS = 9;

  // frame rate window and rate thresholds
  localparam longint unsigned CLK_HZ = 100_000_000;
  localparam longint unsigned FS_MIN_HZ = 20_000;
  localparam longint unsigned FS_MAX_HZ = 216_000;
  localparam longint unsigned FS_128_HZ = 108_000;
  localparam longint unsigned FS_256_HZ = 54_000;
  localparam int unsigned PER_W = 13;
  // longest frame period rounds down, shortest rounds up
  localparam int unsigned PER_MAX_CYC = 32'(CLK_HZ / FS_MIN_HZ);
  localparam int unsigned PER_MIN_CYC =
    32'((CLK_HZ + FS_MAX_HZ - 1) / FS_MAX_HZ);
  localparam logic [PER_W-1:0] PER_128_CYC = PER_W'(CLK_HZ / FS_128_HZ);
  localparam logic [PER_W-1:0] PER_256_CYC = PER_W'(CLK_HZ / FS_256_HZ);

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [WB_SEL_W-1:0] sel;
    logic [WB_ADR_W-1:0] adr;
    logic [WB_DAT_W-1:0] dat;
  } ars_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [WB_DAT_W-1:0] dat;
  } ars_wb_rsp_t;

  // condition levels from the decoder; bit 2 takes both lock levels, every other event bit one each
  typedef struct packed {
    logic chan_stat_crc_err;
    logic parity_err;
    logic validity_flag;
    logic biphase_err;
    logic subcode_changed;
    logic decoder_locked;
    logic pll_locked;
    logic subcode_crc_err;
    logic buffer_xfer_done;
  } ars_dec_stat_t;

endpackage : ars_pkg

// *** core/ars_status_regs.sv ***
// receiver status register bank: rate estimation, event status, interrupt
// assumes synchronous decoder levels, a frame strobe, and a wishbone master
//
// Contract
// - rate register bits 1:0 give undetermined, 128, 256 or 512 fs
// - estimate frame rate, pick max clock rate, drive pll and status
// - a flag interrupts only when unmasked; masked flags still report
// - event bit 7 set on channel status crc error, else zero
// - bit 6 parity error, bit 4 biphase error, zero otherwise
// - bit 5 is one when the stream marks audio not valid
// - bit 3 set when subcode data changed; software then reads it
// - bit 2 set while decoder or pll unlocked, clear when both lock
// - bit 1 set on subcode crc error, else zero
// - bit 0 set when buffer transfer completed, else zero
// - both status registers are read only to the host
`timescale 1ns/100ps
module ars_status_regs #(
  parameter int unsigned PER_MAX = ars_pkg::PER_MAX_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ars_pkg::ars_wb_req_t wb_req_i,
  output ars_pkg::ars_wb_rsp_t wb_rsp_o,
  input wire logic frame_strobe_i,
  input wire ars_pkg::ars_dec_stat_t dec_stat_i,
  output ars_pkg::ars_rate_t clock_recovery_pll_rate_o,
  output logic recovered_clock_output_o,
  output logic irq_o
);
  import ars_pkg::*;

  typedef enum logic [1:0] {
    EST_IDLE,
    EST_MEASURE
  } ars_est_t;

  localparam logic [PER_W-1:0] PER_MAX_L = PER_W'(PER_MAX);
  localparam logic [PER_W-1:0] PER_MIN_L = PER_W'(PER_MIN_CYC);
  localparam logic [PER_W-1:0] ONE_CYC = PER_W'(1);

  function automatic ars_rate_t rate_of(input logic [PER_W-1:0] per);
    if (per < PER_128_CYC) begin
      rate_of = RATE_128FS;
    end else if (per < PER_256_CYC) begin
      rate_of = RATE_256FS;
    end else begin
      rate_of = RATE_512FS;
    end
  endfunction : rate_of

  function automatic logic [PER_W-1:0] div_of(input logic [PER_W-1:0] per,
                                              input ars_rate_t rate);
    logic [PER_W-1:0] d;
    d = per >> SHIFT_512FS;
    unique case (rate)
      RATE_128FS: d = per >> SHIFT_128FS;
      RATE_256FS: d = per >> SHIFT_256FS;
      RATE_512FS: d = per >> SHIFT_512FS;
      RATE_UNDET: d = ONE_CYC;
    endcase
    div_of = (d == '0) ? ONE_CYC : d;
  endfunction : div_of

  function automatic logic reg_hit(input ars_wb_req_t r,
                                   input logic [7:0] idx);
    reg_hit = (r.adr[WB_ADR_W-1:IDX_LSB] == idx[WB_ADR_W-IDX_LSB-1:0]);
  endfunction : reg_hit

  ars_est_t est_ff;
  ars_est_t nxt_est;
  logic [PER_W-1:0] per_cnt_ff;
  logic [PER_W-1:0] nxt_per_cnt;
  logic [PER_W-1:0] per_ff;
  ars_rate_t rate_ff;
  ars_rate_t nxt_rate;
  logic [PER_W-1:0] div_ff;
  logic [PER_W-1:0] ck_cnt_ff;
  logic ck_pulse_ff;
  logic [REG_W-1:0] evt_ff;
  logic [REG_W-1:0] evt_prev_ff;
  logic [REG_W-1:0] mask_ff;
  logic [REG_W-1:0] pend_ff;
  logic [REG_W-1:0] nxt_evt;
  logic [REG_W-1:0] evt_rise;
  logic [REG_W-1:0] pend_clr;
  logic [REG_W-1:0] rd_byte;
  logic ack_ff;
  logic [WB_DAT_W-1:0] rd_dat_ff;
  logic locked;
  logic req;
  logic wr_strobe;
  logic per_ok;

  assign locked = dec_stat_i.decoder_locked & dec_stat_i.pll_locked;
  assign req = wb_req_i.cyc & wb_req_i.stb & ~ack_ff;
  assign wr_strobe = req & wb_req_i.we & wb_req_i.sel[0];
  assign per_ok = (per_cnt_ff >= PER_MIN_L) && (per_cnt_ff <= PER_MAX_L);

  // frame period measurement between consecutive frame strobes
  always_comb begin
    nxt_est = est_ff;
    nxt_per_cnt = per_cnt_ff;
    nxt_rate = rate_ff;
    unique case (est_ff)
      EST_IDLE: begin
        nxt_rate = RATE_UNDET;
        nxt_per_cnt = ONE_CYC;
        if (frame_strobe_i && locked) begin
          nxt_est = EST_MEASURE;
        end
      end
      EST_MEASURE: begin
        if (!locked) begin
          nxt_est = EST_IDLE;
          nxt_rate = RATE_UNDET;
        end else if (frame_strobe_i) begin
          nxt_per_cnt = ONE_CYC;
          nxt_rate = per_ok ? rate_of(per_cnt_ff) : RATE_UNDET;
        end else if (per_cnt_ff > PER_MAX_L) begin
          // frames stopped: forget the rate rather than hold a stale one
          nxt_est = EST_IDLE;
          nxt_rate = RATE_UNDET;
        end else begin
          nxt_per_cnt = per_cnt_ff + ONE_CYC;
        end
      end
      default: begin
        nxt_est = EST_IDLE;
        nxt_rate = RATE_UNDET;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      est_ff <= EST_IDLE;
      per_cnt_ff <= ONE_CYC;
      rate_ff <= RATE_UNDET;
    end else begin
      est_ff <= nxt_est;
      per_cnt_ff <= nxt_per_cnt;
      rate_ff <= nxt_rate;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      per_ff <= ONE_CYC;
    end else if (est_ff == EST_MEASURE && frame_strobe_i && per_ok) begin
      per_ff <= per_cnt_ff;
    end
  end

  // recovered clock enable: frame period split into the chosen multiple
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_ff <= ONE_CYC;
      ck_cnt_ff <= '0;
      ck_pulse_ff <= 1'b0;
    end else begin
      div_ff <= div_of(per_ff, rate_ff);
      if (rate_ff == RATE_UNDET || frame_strobe_i) begin
        ck_cnt_ff <= '0;
        ck_pulse_ff <= 1'b0;
      end else if (ck_cnt_ff >= div_ff - ONE_CYC) begin
        ck_cnt_ff <= '0;
        ck_pulse_ff <= 1'b1;
      end else begin
        ck_cnt_ff <= ck_cnt_ff + ONE_CYC;
        ck_pulse_ff <= 1'b0;
      end
    end
  end

  // live event status, one cycle behind the decoder levels
  always_comb begin
    nxt_evt = '0;
    nxt_evt[BIT_CS_CRC] = dec_stat_i.chan_stat_crc_err;
    nxt_evt[BIT_PARITY] = dec_stat_i.parity_err;
    nxt_evt[BIT_VALIDITY] = dec_stat_i.validity_flag;
    nxt_evt[BIT_BIPHASE] = dec_stat_i.biphase_err;
    nxt_evt[BIT_SUB_CHG] = dec_stat_i.subcode_changed;
    nxt_evt[BIT_UNLOCK] = ~locked;
    nxt_evt[BIT_SUB_CRC] = dec_stat_i.subcode_crc_err;
    nxt_evt[BIT_XFER] = dec_stat_i.buffer_xfer_done;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_ff <= '0;
      evt_prev_ff <= '0;
    end else begin
      evt_ff <= nxt_evt;
      evt_prev_ff <= evt_ff;
    end
  end

  assign evt_rise = evt_ff & ~evt_prev_ff;
  assign pend_clr = (wr_strobe && reg_hit(wb_req_i, REG_PEND_IDX)) ?
                    wb_req_i.dat[REG_W-1:0] : '0;

  // sticky pending bits: a new rise in the clearing cycle survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_ff <= PEND_RESET;
    end else begin
      pend_ff <= (pend_ff & ~pend_clr) | evt_rise;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_ff <= MASK_RESET;
    end else if (wr_strobe && reg_hit(wb_req_i, REG_MASK_IDX)) begin
      mask_ff <= wb_req_i.dat[REG_W-1:0];
    end
  end

  // read mux; writes to the two status registers are acked and dropped
  always_comb begin
    rd_byte = '0;
    if (reg_hit(wb_req_i, REG_CLK_RATE_IDX)) begin
      rd_byte = {6'h00, rate_ff};
    end else if (reg_hit(wb_req_i, REG_EVENT_IDX)) begin
      rd_byte = evt_ff;
    end else if (reg_hit(wb_req_i, REG_MASK_IDX)) begin
      rd_byte = mask_ff;
    end else if (reg_hit(wb_req_i, REG_PEND_IDX)) begin
      rd_byte = pend_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rd_dat_ff <= '0;
    end else begin
      ack_ff <= req;
      if (req && !wb_req_i.we) begin
        rd_dat_ff <= {{(WB_DAT_W-REG_W){1'b0}}, rd_byte};
      end else begin
        rd_dat_ff <= '0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(pend_ff & mask_ff);
    end
  end

  assign wb_rsp_o.ack = ack_ff;
  assign wb_rsp_o.dat = rd_dat_ff;
  assign clock_recovery_pll_rate_o = rate_ff;
  assign recovered_clock_output_o = ck_pulse_ff;

endmodule : ars_status_regs

// *** dv/ars_frame_src.sv ***
// frame strobe source standing in for the biphase decoder front end
// assumes the bench sets a period in clock cycles, zero for no frames
`timescale 1ns/100ps
module ars_frame_src (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] period_i,
  output logic frame_strobe_o
);
  logic [15:0] cnt_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i || period_i == 16'h0) begin
      cnt_ff <= 16'h0;
      frame_strobe_o <= 1'b0;
    end else begin
      frame_strobe_o <= (cnt_ff == period_i - 16'h1);
      cnt_ff <= (cnt_ff == period_i - 16'h1) ? 16'h0 : cnt_ff + 16'h1;
    end
  end
endmodule : ars_frame_src

// *** dv/ars_status_regs_chk.sv ***
// assertions on the receiver status bank ports
// assumes one clock domain and a synchronous active high reset
`timescale 1ns/100ps
module ars_status_regs_chk import ars_pkg::*; #(
  parameter int unsigned PER_MAX = ars_pkg::PER_MAX_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ars_pkg::ars_wb_req_t wb_req_i,
  input wire ars_pkg::ars_wb_rsp_t wb_rsp_o,
  input wire logic frame_strobe_i,
  input wire ars_pkg::ars_dec_stat_t dec_stat_i,
  input wire ars_pkg::ars_rate_t clock_recovery_pll_rate_o,
  input wire logic recovered_clock_output_o,
  input wire logic irq_o
);
  logic lk;
  logic [7:0] ev;
  logic rq;
  assign lk = dec_stat_i.decoder_locked & dec_stat_i.pll_locked;
  assign ev = {dec_stat_i[8:5], dec_stat_i.subcode_changed, ~lk,
    dec_stat_i[1:0]};
  assign rq = wb_req_i.cyc & wb_req_i.stb & ~wb_req_i.we;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack held");
  a_ack_taken: assert property (wb_req_i.cyc && wb_req_i.stb &&
    !wb_rsp_o.ack |=> wb_rsp_o.ack) else $error("ack late");
  a_ack_cause: assert property (wb_rsp_o.ack |->
    $past(wb_req_i.cyc && wb_req_i.stb)) else $error("ack unasked");
  a_dat_idle: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0)
    else $error("data without ack");
  a_rate_read: assert property (
    wb_rsp_o.ack && $past(rq && wb_req_i.adr == 8'h4C) |->
    wb_rsp_o.dat == {30'h0, $past(clock_recovery_pll_rate_o)})
    else $error("rate read");
  a_event_read: assert property (
    wb_rsp_o.ack && $past(rq && wb_req_i.adr == 8'h50) |->
    wb_rsp_o.dat == {24'h0, $past(ev, 2)}) else $error("event read");
  a_rate_cause: assert property (
    $changed(clock_recovery_pll_rate_o) && clock_recovery_pll_rate_o !=
    RATE_UNDET |-> $past(frame_strobe_i)) else $error("rate no frame");
  a_rate_unlock: assert property (
    !lk |-> ##[1:3] clock_recovery_pll_rate_o == RATE_UNDET)
    else $error("rate kept when unlocked");
  // cycles since the last frame strobe, saturating
  logic [15:0] gap_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i || frame_strobe_i) begin
      gap_ff <= 16'h0;
    end else if (gap_ff != 16'hFFFF) begin
      gap_ff <= gap_ff + 16'h1;
    end
  end
  a_rate_stale: assert property (
    gap_ff > 16'(PER_MAX + 1) |-> clock_recovery_pll_rate_o == RATE_UNDET)
    else $error("rate kept without frames");
endmodule : ars_status_regs_chk
bind ars_status_regs ars_status_regs_chk #(.PER_MAX(PER_MAX)) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
  .frame_strobe_i(frame_strobe_i), .dec_stat_i(dec_stat_i),
  .clock_recovery_pll_rate_o(clock_recovery_pll_rate_o),
  .recovered_clock_output_o(recovered_clock_output_o), .irq_o(irq_o));

// *** dv/ars_status_regs_tb.sv ***
// self-checking bench for the receiver status bank
// assumes the frame source model and the bound checker
`timescale 1ns/100ps
module ars_status_regs_tb;
  import ars_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  ars_wb_req_t req = '0;
  ars_wb_rsp_t rsp;
  ars_dec_stat_t ds = 9'h00C;
  ars_rate_t rate;
  logic fs, rclk, irq;
  logic [15:0] per = 16'h0;
  logic [31:0] rd;
  logic [31:0] xr;
  int errors = 0;
  int n_compared = 0;
  initial forever #5 clk_i = ~clk_i;
  ars_frame_src i_src (.clk_i(clk_i), .rst_i(rst_i), .period_i(per),
    .frame_strobe_o(fs));
  ars_status_regs #(.PER_MAX(2000)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(req), .wb_rsp_o(rsp), .frame_strobe_i(fs), .dec_stat_i(ds),
    .clock_recovery_pll_rate_o(rate), .recovered_clock_output_o(rclk),
    .irq_o(irq));
  task automatic end_of_test;
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // one classic cycle; a gap cycle precedes it so stb never rejoins ack
  task automatic wb(input logic we, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 20);
    rd = rsp.dat;
    req <= '0;
    if (n >= 20) begin
      errors++;
      end_of_test();
    end
  endtask : wb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    cmp(rd, exp);
  endtask : rdc
  // raise one decoder condition, read it back as its event bit, drop it
  task automatic evt(input int b);
    ds <= 9'h00C ^ ((b > 2) ? 9'(1 << (b + 1)) :
      (b == 2) ? 9'h00C : 9'(1 << b));
    repeat (3) @(posedge clk_i);
    rdc(8'h50, 32'(1 << b));
    ds <= 9'h00C;
    @(posedge clk_i);
  endtask : evt
  // recovered clock pulses between two frame strobes
  task automatic rck(input int p, input int s);
    int n;
    int m;
    n = 0;
    m = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (fs !== 1'b1 && n < 3000);
    do begin
      @(posedge clk_i);
      n++;
      if (rclk === 1'b1) m++;
    end while (fs !== 1'b1 && n < 6000);
    if (n >= 6000) begin
      errors++;
      end_of_test();
    end
    cmp(32'(m), 32'((p - 1) / (p >> s)));
  endtask : rck
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(8'h4C, 32'h0);
    rdc(8'h58, 32'h0);
    evt(7);
    evt(6);
    evt(5);
    evt(4);
    evt(3);
    evt(2);
    evt(1);
    evt(0);
    rdc(8'h68, 32'hFF);
    cmp({31'h0, irq}, 32'h0);
    wb(1'b1, 8'h58, 32'h40);
    @(posedge clk_i);
    cmp({31'h0, irq}, 32'h1);
    wb(1'b1, 8'h68, 32'h40);
    @(posedge clk_i);
    cmp({31'h0, irq}, 32'h0);
    rdc(8'h68, 32'hBF);
    wb(1'b1, 8'h4C, 32'hFF);
    wb(1'b1, 8'h50, 32'hFF);
    rdc(8'h4C, 32'h0);
    rdc(8'h50, 32'h0);
    rdc(8'h7C, 32'h0);
    // one period per rate band, the last at the longest accepted frame
    for (int k = 0; k < 3; k++) begin
      per <= (k == 0) ? 16'd800 : (k == 1) ? 16'd1500 : 16'd2000;
      repeat (3 * 2000) @(posedge clk_i);
      xr = (per < PER_128_CYC) ? 32'h1 : (per < PER_256_CYC) ? 32'h2 : 32'h3;
      rdc(8'h4C, xr);
      cmp({30'h0, rate}, xr);
      rck(per, 6 + int'(xr));
    end
    ds <= 9'h000;
    repeat (4) @(posedge clk_i);
    rdc(8'h4C, 32'h0);
    ds <= 9'h00C;
    repeat (3 * 2000) @(posedge clk_i);
    rdc(8'h4C, 32'h3);
    // frames stop: the rate must be forgotten after the longest period
    per <= 16'h0;
    repeat (2100) @(posedge clk_i);
    rdc(8'h4C, 32'h0);
    cmp({30'h0, rate}, 32'h0);
    end_of_test();
  end
endmodule : ars_status_regs_tb
